//--- logic/fpcs_sequencer.sv
// Front-panel configuration and run-mode controller of a chassis control module.
// Assumes active-high button pins from outside the clock domain and a host port
// on sys_clk for the lock state that arrives over the control link.
//
// Summary of operation
// R1 - Enter configuration at power-up and when both buttons are held in run mode.
// R2 - Value key increments rack address; lower display shows it.
// R3 - Rack addresses 00 to 99; 00 is master, others slave.
// R4 - Next key goes to site step on master, control-link rate on slave.
// R5 - Value key cycles site 01 to 20; next key goes to control-link rate.
// R6 - Value key cycles control-link rates up to 9600 bps on lower display.
// R7 - Next key stores control-link rate and goes to auxiliary rate step.
// R8 - Value key cycles auxiliary rate; next key accepts; used on master only. The code enters this step on a slave as well, after the control-link rate step.
// R9 - Host must match master control-link rate; rates within factor two.
// R10 - Slave control-link rate must equal its master's auxiliary rate.
// R11 - First run entry shows rack banner above and blank below.
// R12 - Local indicator lit when unlocked, remote indicator lit when locked.
// R13 - Unlocked: rack button toggles all cards, card button toggles one.
// R14 - Switch buttons act only after a continuous two-second hold.
// R15 - Locked rack ignores rack and card buttons; host alone unlocks.
// R16 - Value cycles wrap from highest back to lowest.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defs.svh"

module fpcs_sequencer #(
    parameter int unsigned HOLD_CYCLES = `FPCS_HOLD_CYCLES
) (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire logic                     keyNext,
    input  wire logic                     keyValue,
    input  wire logic                     rackSwitchBtn,
    input  wire logic [`FPCS_NCARD-1:0]   cardBtn,
    input  wire fpcs_pkg::fpcs_bus_req_t  busReq,
    output logic [31:0]                   busRdata,
    output fpcs_pkg::fpcs_disp_t          dispSeg,
    output logic                          localLed,
    output logic                          remoteLed,
    output logic [`FPCS_NCARD-1:0]        cardPos
);
    fpcs_pkg::fpcs_state_t  state;
    fpcs_pkg::fpcs_state_t  next_state;
    logic                   nextSync1;
    logic                   nextSync2;
    logic                   valueSync1;
    logic                   valueSync2;
    logic                   nextPrev;
    logic                   valuePrev;
    logic                   nextPress;
    logic                   valuePress;
    logic                   bothHeld;
    logic [7:0]             rackAddr;
    logic [7:0]             siteNum;
    logic [2:0]             ctlRateEdit;
    logic [2:0]             ctlRate;
    logic [2:0]             auxRate;
    logic                   locked;
    logic                   rackFire;
    logic [`FPCS_NCARD-1:0] cardFire;
    logic [3:0][3:0]        upperGlyph;
    logic [3:0][3:0]        lowerGlyph;

    // Two-digit BCD increment, 99 wraps to 00
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r[3:0] = 4'h0;
            r[7:4] = (v[7:4] == 4'h9) ? 4'h0 : v[7:4] + 4'h1;
        end else begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    // Rate index to four BCD digits, lowest rate first, 9600 highest
    function automatic logic [15:0] rateBcd(input logic [2:0] idx);
        logic [15:0] r;
        r = 16'h9600;
        unique case (idx)
            3'h0:    r = 16'h0300;
            3'h1:    r = 16'h0600;
            3'h2:    r = 16'h1200;
            3'h3:    r = 16'h2400;
            3'h4:    r = 16'h4800;
            default: r = 16'h9600;
        endcase
        return r;
    endfunction

    // Glyph code to segments g..a, active high
    function automatic logic [6:0] seg7(input logic [3:0] g);
        logic [6:0] s;
        s = 7'h00;
        unique case (g)
            4'h0:          s = 7'h3f;
            4'h1:          s = 7'h06;
            4'h2:          s = 7'h5b;
            4'h3:          s = 7'h4f;
            4'h4:          s = 7'h66;
            4'h5:          s = 7'h6d;
            4'h6:          s = 7'h7d;
            4'h7:          s = 7'h07;
            4'h8:          s = 7'h7f;
            4'h9:          s = 7'h6f;
            `FPCS_GLYPH_R: s = 7'h50;
            `FPCS_GLYPH_C: s = 7'h58;
            default:       s = 7'h00;
        endcase
        return s;
    endfunction

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            nextSync1  <= 1'b0;
            nextSync2  <= 1'b0;
            valueSync1 <= 1'b0;
            valueSync2 <= 1'b0;
            nextPrev   <= 1'b0;
            valuePrev  <= 1'b0;
        end else begin
            nextSync1  <= keyNext;
            nextSync2  <= nextSync1;
            valueSync1 <= keyValue;
            valueSync2 <= valueSync1;
            nextPrev   <= nextSync2;
            valuePrev  <= valueSync2;
        end
    end

    // A press while the other key is down is a chord, not a step
    assign bothHeld   = nextSync2 & valueSync2;
    assign nextPress  = nextSync2 & ~nextPrev & ~valueSync2;
    assign valuePress = valueSync2 & ~valuePrev & ~nextSync2;

    always_comb begin
        next_state = state;
        unique case (state)
            fpcs_pkg::ST_ADDR: begin
                if (nextPress) begin
                    next_state = (rackAddr == `FPCS_ADDR_MASTER) ?
                                 fpcs_pkg::ST_SITE : fpcs_pkg::ST_CTLRATE;  // [R3] [R4]
                end
            end
            fpcs_pkg::ST_SITE: begin
                if (nextPress) begin
                    next_state = fpcs_pkg::ST_CTLRATE;  // [R5]
                end
            end
            fpcs_pkg::ST_CTLRATE: begin
                if (nextPress) begin
                    next_state = fpcs_pkg::ST_AUXRATE;  // [R7]
                end
            end
            fpcs_pkg::ST_AUXRATE: begin
                if (nextPress) begin
                    next_state = fpcs_pkg::ST_RUN;  // [R8]
                end
            end
            fpcs_pkg::ST_RUN: begin
                if (bothHeld) begin
                    next_state = fpcs_pkg::ST_ADDR;  // [R1]
                end
            end
            default: next_state = fpcs_pkg::ST_ADDR;
        endcase
    end

    // No stored setup survives power loss, so reset always lands in configuration
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= fpcs_pkg::ST_ADDR;  // [R1]
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rackAddr <= `FPCS_RST_ADDR;
            siteNum  <= `FPCS_RST_SITE;
        end else if (valuePress) begin
            if (state == fpcs_pkg::ST_ADDR) begin
                rackAddr <= bcdInc(rackAddr);  // [R2] [R3] [R16]
            end
            if (state == fpcs_pkg::ST_SITE) begin
                siteNum <= (siteNum == `FPCS_SITE_MAX) ?
                           `FPCS_SITE_MIN : bcdInc(siteNum);  // [R5] [R16]
            end
        end
    end

    // The edited control-link rate only takes effect once its step is accepted; the aux rate changes on each press
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctlRateEdit <= `FPCS_RST_RATE;
            ctlRate     <= `FPCS_RST_RATE;
            auxRate     <= `FPCS_RST_RATE;
        end else if (state == fpcs_pkg::ST_CTLRATE) begin
            if (valuePress) begin
                ctlRateEdit <= (ctlRateEdit == `FPCS_NRATE - 3'h1) ?
                               3'h0 : ctlRateEdit + 3'h1;  // [R6] [R16]
            end
            if (nextPress) begin
                ctlRate <= ctlRateEdit;  // [R7]
            end
        end else if (state == fpcs_pkg::ST_AUXRATE && valuePress) begin
            auxRate <= (auxRate == `FPCS_NRATE - 3'h1) ?
                       3'h0 : auxRate + 3'h1;  // [R8] [R16]
        end
    end

    // Lock is only ever changed by the host; the panel has no path to it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            locked <= `FPCS_RST_LOCK;
        end else if (busReq.wr && busReq.addr == `FPCS_REG_CTRL) begin
            locked <= busReq.wdata[`FPCS_CTRL_LOCK_BIT];  // [R15]
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busRdata <= 32'h0;
        end else begin
            busRdata <= 32'h0;
            if (busReq.rd) begin
                unique case (busReq.addr)
                    `FPCS_REG_CTRL: begin
                        busRdata[`FPCS_CTRL_LOCK_BIT] <= locked;
                    end
                    `FPCS_REG_STATUS: begin
                        busRdata[`FPCS_ST_STATE_LSB +: 5] <= state;
                        busRdata[`FPCS_ST_LOCK_BIT]       <= locked;
                        busRdata[`FPCS_ST_ADDR_LSB +: 8]  <= rackAddr;
                        busRdata[`FPCS_ST_SITE_LSB +: 8]  <= siteNum;
                        busRdata[`FPCS_ST_CTL_LSB +: 3]   <= ctlRate;
                        busRdata[`FPCS_ST_AUX_LSB +: 3]   <= auxRate;
                    end
                    `FPCS_REG_CARDS: begin
                        busRdata[`FPCS_NCARD-1:0] <= cardPos;
                    end
                    default: busRdata <= 32'h0;
                endcase
            end
        end
    end

    fpcs_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) rackHold (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .btnPin   (rackSwitchBtn),
        .holdFire (rackFire)
    );

    genvar c;
    generate
        for (c = 0; c < `FPCS_NCARD; c = c + 1) begin : gCard
            fpcs_hold_timer #(
                .HOLD_CYCLES (HOLD_CYCLES)
            ) cardHold (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .btnPin   (cardBtn[c]),
                .holdFire (cardFire[c])
            );
        end
    endgenerate

    // Rack and card requests in one cycle cancel, so that card keeps its position
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cardPos <= '0;
        end else if (state == fpcs_pkg::ST_RUN && !locked) begin  // [R15]
            cardPos <= cardPos ^ ({`FPCS_NCARD{rackFire}} ^ cardFire);  // [R13] [R14]
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            localLed  <= 1'b1;
            remoteLed <= 1'b0;
        end else begin
            localLed  <= ~locked;  // [R12]
            remoteLed <= locked;   // [R12]
        end
    end

    always_comb begin
        upperGlyph = {4{`FPCS_GLYPH_BLANK}};
        lowerGlyph = {4{`FPCS_GLYPH_BLANK}};
        unique case (state)
            fpcs_pkg::ST_ADDR: begin
                lowerGlyph[1:0] = {rackAddr[7:4], rackAddr[3:0]};  // [R2]
            end
            fpcs_pkg::ST_SITE: begin
                lowerGlyph[1:0] = {siteNum[7:4], siteNum[3:0]};  // [R5]
            end
            fpcs_pkg::ST_CTLRATE: begin
                lowerGlyph = rateBcd(ctlRateEdit);  // [R6]
            end
            fpcs_pkg::ST_AUXRATE: begin
                lowerGlyph = rateBcd(auxRate);  // [R8]
            end
            fpcs_pkg::ST_RUN: begin
                upperGlyph = {`FPCS_GLYPH_R, `FPCS_GLYPH_C,
                              rackAddr[7:4], rackAddr[3:0]};  // [R11]
            end
            default: begin
                upperGlyph = {4{`FPCS_GLYPH_BLANK}};
            end
        endcase
    end

    genvar d;
    generate
        for (d = 0; d < 4; d = d + 1) begin : gDigit
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    dispSeg.upper[d] <= 7'h00;
                    dispSeg.lower[d] <= 7'h00;
                end else begin
                    dispSeg.upper[d] <= seg7(upperGlyph[d]);
                    dispSeg.lower[d] <= seg7(lowerGlyph[d]);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- shared/fpcs_defs.svh
// Constants of the front-panel configuration sequencer: counts, offsets, fields, resets.
// Assumes a single 25 MHz system clock and BCD-coded addresses and site numbers.
`ifndef FPCS_DEFS_SVH
`define FPCS_DEFS_SVH

`define FPCS_NCARD          8
`define FPCS_CLK_KHZ        25000
`define FPCS_HOLD_MS        2000
`define FPCS_HOLD_CYCLES    (`FPCS_HOLD_MS * `FPCS_CLK_KHZ)

`define FPCS_NRATE          3'h6
`define FPCS_ADDR_MASTER    8'h00
`define FPCS_SITE_MIN       8'h01
`define FPCS_SITE_MAX       8'h20

`define FPCS_RST_ADDR       8'h00
`define FPCS_RST_SITE       8'h01
`define FPCS_RST_RATE       3'h5
`define FPCS_RST_LOCK       1'b0

`define FPCS_REG_CTRL       4'h0
`define FPCS_REG_STATUS     4'h4
`define FPCS_REG_CARDS      4'h8

`define FPCS_CTRL_LOCK_BIT  0
`define FPCS_ST_STATE_LSB   0
`define FPCS_ST_LOCK_BIT    5
`define FPCS_ST_ADDR_LSB    8
`define FPCS_ST_SITE_LSB    16
`define FPCS_ST_CTL_LSB     24
`define FPCS_ST_AUX_LSB     28

`define FPCS_GLYPH_R        4'ha
`define FPCS_GLYPH_C        4'hb
`define FPCS_GLYPH_BLANK    4'hf

`endif

//--- shared/fpcs_pkg.sv
// Types of the front-panel configuration sequencer.
// Assumes fpcs_defs.svh supplies the numeric constants.
package fpcs_pkg;

    typedef enum logic [4:0] {
        ST_ADDR    = 5'h01,
        ST_SITE    = 5'h02,
        ST_CTLRATE = 5'h04,
        ST_AUXRATE = 5'h08,
        ST_RUN     = 5'h10
    } fpcs_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } fpcs_bus_req_t;

    typedef struct packed {
        logic [3:0][6:0] upper;
        logic [3:0][6:0] lower;
    } fpcs_disp_t;

endpackage

//--- logic/fpcs_hold_timer.sv
// Hold qualifier for one switch button: pulses once after a continuous hold.
// Assumes an asynchronous, active-high button pin; it is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defs.svh"

module fpcs_hold_timer #(
    parameter int unsigned HOLD_CYCLES = `FPCS_HOLD_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic btnPin,
    output logic      holdFire
);
    logic        sync1;
    logic        sync2;
    logic [31:0] holdCount;
    logic        fired;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= btnPin;
            sync2 <= sync1;
        end
    end

    // A release restarts the count, so short presses never fire
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            holdCount <= 32'h0;
            fired     <= 1'b0;
            holdFire  <= 1'b0;
        end else begin
            holdFire <= 1'b0;
            if (!sync2) begin
                holdCount <= 32'h0;
                fired     <= 1'b0;
            end else if (!fired) begin
                if (holdCount == HOLD_CYCLES - 1) begin  // [R14]
                    holdFire <= 1'b1;
                    fired    <= 1'b1;
                end else begin
                    holdCount <= holdCount + 32'h1;
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- verification/fpcs_sequencer_assertions.sv
// Concurrent checks on the front-panel sequencer, seeing its top-level ports only.
// Assumes the bench keeps lock writes well apart from switch holds.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defs.svh"

module fpcs_sequencer_checker #(
    parameter int unsigned HOLD_CYCLES = 8
) (
    input wire logic                    sys_clk,
    input wire logic                    resetn,
    input wire logic                    keyNext,
    input wire logic                    keyValue,
    input wire logic                    rackSwitchBtn,
    input wire logic [`FPCS_NCARD-1:0]  cardBtn,
    input wire fpcs_pkg::fpcs_bus_req_t busReq,
    input wire logic [31:0]             busRdata,
    input wire fpcs_pkg::fpcs_disp_t    dispSeg,
    input wire logic                    localLed,
    input wire logic                    remoteLed,
    input wire logic [`FPCS_NCARD-1:0]  cardPos
);
    // Cycles any switch pin has been high without a break
    logic [31:0] heldRun;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            heldRun <= 32'h0;
        end else if (rackSwitchBtn || cardBtn != '0) begin
            heldRun <= heldRun + 32'h1;
        end else begin
            heldRun <= 32'h0;
        end
    end

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    leds_exclusive_a: assert property (localLed != remoteLed)
        else $error("local and remote indicators agree");
    lock_write_a: assert property (busReq.wr && busReq.addr == `FPCS_REG_CTRL
        |-> ##2 remoteLed == $past(busReq.wdata[0], 2))
        else $error("remote indicator does not follow lock write");
    host_lock_a: assert property ($rose(remoteLed) |-> $past(busReq.wr, 2))
        else $error("lock set without host write");
    // The indicator lags the lock by the same cycle as the card update
    locked_cards_a: assert property ($changed(cardPos) |-> !remoteLed)
        else $error("card moved while locked");
    hold_time_a: assert property ($changed(cardPos) |-> heldRun >= HOLD_CYCLES)
        else $error("card moved before full hold");
    banner_blank_a: assert property (dispSeg.upper[3] == 7'h50
        |-> dispSeg.upper[2] == 7'h58 && dispSeg.lower == '0)
        else $error("run banner or blank lower display wrong");
    cards_read_a: assert property ($past(busReq.rd)
        && $past(busReq.addr) == `FPCS_REG_CARDS |-> busRdata == {24'h0, $past(cardPos)})
        else $error("card read data wrong");
    unmapped_read_a: assert property ($past(busReq.rd) && !($past(busReq.addr) inside
        {`FPCS_REG_CTRL, `FPCS_REG_STATUS, `FPCS_REG_CARDS}) |-> busRdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!$past(busReq.rd) |-> busRdata == 32'h0)
        else $error("read data outside read cycle");
endmodule

bind fpcs_sequencer fpcs_sequencer_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
    .sys_clk(sys_clk), .resetn(resetn), .keyNext(keyNext), .keyValue(keyValue),
    .rackSwitchBtn(rackSwitchBtn), .cardBtn(cardBtn), .busReq(busReq),
    .busRdata(busRdata), .dispSeg(dispSeg), .localLed(localLed),
    .remoteLed(remoteLed), .cardPos(cardPos));

`default_nettype wire

//--- verification/fpcs_operator.sv
// Operator at the panel: presses step keys and holds switch buttons.
// Assumes it is driven through its tasks from the bench, on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defs.svh"

module fpcs_operator (
    input  wire logic                   sys_clk,
    output logic                        keyNext,
    output logic                        keyValue,
    output logic                        rackSwitchBtn,
    output logic [`FPCS_NCARD-1:0]      cardBtn
);
    initial begin
        keyNext = 1'b0;
        keyValue = 1'b0;
        rackSwitchBtn = 1'b0;
        cardBtn = '0;
    end

    // Rates picked here must suit the host port and the master link
    // Four cycles up and down, so each press clears the synchroniser once
    task automatic press(input logic nxt, input logic val, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            keyNext <= nxt;
            keyValue <= val;
            repeat (4) @(posedge sys_clk);
            keyNext <= 1'b0;
            keyValue <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask

    task automatic hold(input logic rack, input logic [`FPCS_NCARD-1:0] cards, input int n);
        @(posedge sys_clk);
        rackSwitchBtn <= rack;
        cardBtn <= cards;
        repeat (n) @(posedge sys_clk);
        rackSwitchBtn <= 1'b0;
        cardBtn <= '0;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule

`default_nettype wire

//--- verification/front_panel_config_sequencer_tb_top.sv
// Self-checking bench for the front-panel sequencer with an operator model.
// Assumes a short hold count so switch holds take a few cycles.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defs.svh"

module front_panel_config_sequencer_tb_top;
    localparam int unsigned HOLD = 8;
    logic                    sys_clk;
    logic                    resetn;
    logic                    keyNext;
    logic                    keyValue;
    logic                    rackSwitchBtn;
    logic [`FPCS_NCARD-1:0]  cardBtn;
    logic [`FPCS_NCARD-1:0]  cardPos;
    fpcs_pkg::fpcs_bus_req_t busReq;
    fpcs_pkg::fpcs_disp_t    dispSeg;
    logic [31:0]             busRdata;
    logic [31:0]             rdv;
    logic                    localLed;
    logic                    remoteLed;
    int                      nFail;
    int                      nCompared;

    fpcs_sequencer #(.HOLD_CYCLES(HOLD)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .keyNext(keyNext), .keyValue(keyValue),
        .rackSwitchBtn(rackSwitchBtn), .cardBtn(cardBtn), .busReq(busReq),
        .busRdata(busRdata), .dispSeg(dispSeg), .localLed(localLed),
        .remoteLed(remoteLed), .cardPos(cardPos));

    fpcs_operator op_u (
        .sys_clk(sys_clk), .keyNext(keyNext), .keyValue(keyValue),
        .rackSwitchBtn(rackSwitchBtn), .cardBtn(cardBtn));

    always #20 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic busRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1 d = busRdata;
    endtask

    task automatic busWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Unlocked status word: state, address, site, committed and aux rate indices
    task automatic chkSt(input logic [4:0] s, input logic [7:0] a, input logic [7:0] si,
                         input logic [2:0] c, input logic [2:0] x);
        busRd(`FPCS_REG_STATUS, rdv);
        check("status", {1'b0, x, 1'b0, c, si, a, 3'h0, s}, rdv);
    endtask

    task automatic chkLeds(input logic locked);
        check("localLed", {31'h0, !locked}, {31'h0, localLed});
        check("remoteLed", {31'h0, locked}, {31'h0, remoteLed});
    endtask

    // Lower display digits 3..0, segments g..a
    task automatic chkLow(input logic [27:0] exp);
        check("lower", {4'h0, exp}, {4'h0, dispSeg.lower});
    endtask

    task automatic scnReset;
        chkSt(5'h01, 8'h00, 8'h01, 3'h5, 3'h5);
        chkLeds(1'b0);
        chkLow({7'h00, 7'h00, 7'h3f, 7'h3f});
    endtask

    task automatic scnMaster;
        op_u.press(1'b0, 1'b1, 99);
        chkSt(5'h01, 8'h99, 8'h01, 3'h5, 3'h5);
        chkLow({7'h00, 7'h00, 7'h6f, 7'h6f});
        op_u.press(1'b0, 1'b1, 1);
        chkSt(5'h01, 8'h00, 8'h01, 3'h5, 3'h5);
        op_u.press(1'b1, 1'b0, 1);
        chkSt(5'h02, 8'h00, 8'h01, 3'h5, 3'h5);
        op_u.press(1'b0, 1'b1, 19);
        chkSt(5'h02, 8'h00, 8'h20, 3'h5, 3'h5);
        chkLow({7'h00, 7'h00, 7'h5b, 7'h3f});
        op_u.press(1'b0, 1'b1, 1);
        chkSt(5'h02, 8'h00, 8'h01, 3'h5, 3'h5);
        op_u.press(1'b1, 1'b0, 1);
        chkLow({7'h6f, 7'h7d, 7'h3f, 7'h3f});
        op_u.press(1'b0, 1'b1, 1);
        chkSt(5'h04, 8'h00, 8'h01, 3'h5, 3'h5);
        chkLow({7'h3f, 7'h4f, 7'h3f, 7'h3f});
        op_u.press(1'b1, 1'b0, 1);
        chkSt(5'h08, 8'h00, 8'h01, 3'h0, 3'h5);
        op_u.press(1'b0, 1'b1, 2); // aux 600 stays within twice control 300
        chkLow({7'h3f, 7'h7d, 7'h3f, 7'h3f});
        op_u.press(1'b1, 1'b0, 1);
        chkSt(5'h10, 8'h00, 8'h01, 3'h0, 3'h1);
        check("banner", 32'h2858, {18'h0, dispSeg.upper[3], dispSeg.upper[2]});
        check("lower", 32'h0, {4'h0, dispSeg.lower});
    endtask

    task automatic scnSwitch;
        op_u.hold(1'b0, 8'h02, 5);
        check("cardPos", 32'h0, {24'h0, cardPos});
        op_u.hold(1'b0, 8'h02, 16);
        check("cardPos", 32'h2, {24'h0, cardPos});
        op_u.hold(1'b1, 8'h00, 16);
        busRd(`FPCS_REG_CARDS, rdv);
        check("cards", 32'hfd, rdv);
        busWr(`FPCS_REG_CTRL, 32'h1);
        chkLeds(1'b1);
        busRd(`FPCS_REG_CTRL, rdv);
        check("ctrl", 32'h1, rdv);
        op_u.hold(1'b1, 8'h10, 16);
        check("cardPos", 32'hfd, {24'h0, cardPos});
        busWr(`FPCS_REG_CTRL, 32'h0);
        chkLeds(1'b0);
        busRd(4'hc, rdv);
        check("unmapped", 32'h0, rdv);
    endtask

    task automatic scnReenter;
        op_u.press(1'b1, 1'b1, 1);
        chkSt(5'h01, 8'h00, 8'h01, 3'h0, 3'h1);
        op_u.press(1'b0, 1'b1, 1);
        op_u.press(1'b1, 1'b0, 1);
        chkSt(5'h04, 8'h01, 8'h01, 3'h0, 3'h1);
        op_u.press(1'b0, 1'b1, 1); // slave control rate equals master aux
        chkLow({7'h3f, 7'h7d, 7'h3f, 7'h3f});
        op_u.press(1'b1, 1'b0, 1);
        chkSt(5'h08, 8'h01, 8'h01, 3'h1, 3'h1);
    endtask

    task automatic testDone;
        if (nFail == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        nFail++;
        testDone();
    end

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        busReq = '0;
        nFail = 0;
        nCompared = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        scnReset();
        scnMaster();
        scnSwitch();
        scnReenter();
        testDone();
    end
endmodule

`default_nettype wire
